/* hw/isf_core_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module isf_core_seq (
   input wire logic core_clk,
   input wire logic nrst,
   isf_link_if.core link,
   input wire logic [isf_pkg::ADDR_W-1:0] addr,
   input wire logic [isf_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [isf_pkg::DATA_W-1:0] rdata,
   input wire logic core_ready,
   input wire logic core_return,
   output logic vector_valid,
   output logic [3:0] vector_id,
   output logic irq
);
   logic [isf_pkg::CTRL_W-1:0] ctrl_reg;
   logic [isf_pkg::NUM_SRC-1:0] enable_reg;
   logic [isf_pkg::NUM_SRC-1:0] prio_reg;
   logic [isf_pkg::IRQ_W-1:0] irq_status_reg;
   logic [isf_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [isf_pkg::NUM_SW-1:0] sw_clear_reg;
   logic [isf_pkg::DATA_W-1:0] rdata_reg;
   logic vector_valid_reg;
   logic [3:0] vector_id_reg;
   logic inserv_hi_reg;
   logic inserv_lo_reg;
   logic irq_reg;
   logic [isf_pkg::NUM_SRC-1:0] req_en;
   logic [isf_pkg::NUM_SRC-1:0] req_hi;
   logic [isf_pkg::NUM_SRC-1:0] req_lo;
   logic [isf_pkg::NUM_SRC-1:0] pick_vec;
   logic pick_hi;
   logic found;
   logic [3:0] found_id;
   logic take;
   logic ret_hi;
   logic ret_lo;
   logic [isf_pkg::IRQ_W-1:0] irq_set;
   logic [isf_pkg::DATA_W-1:0] rd_mux;
   logic wr_ctrl;
   logic wr_en;
   logic wr_prio;
   logic wr_sw;
   logic wr_ist;
   logic wr_imask;

   assign req_en = link.req & enable_reg & {isf_pkg::NUM_SRC{ctrl_reg[isf_pkg::CTRL_GLOBAL_EN]}};
   assign req_hi = req_en & prio_reg;
   assign req_lo = req_en & ~prio_reg;
   // a high request preempts low service; nothing preempts high service
   assign pick_hi = (|req_hi) & ~inserv_hi_reg;
   assign pick_vec = pick_hi ? req_hi : ((~inserv_hi_reg & ~inserv_lo_reg) ? req_lo : isf_pkg::SRC_RESET);
   assign take = core_ready & found;
   assign ret_hi = core_return & inserv_hi_reg;
   assign ret_lo = core_return & ~inserv_hi_reg;
   assign irq_set = {core_return, take};

   isf_prio_enc u_enc (
      .vec(pick_vec),
      .found(found),
      .id(found_id)
   );

   assign wr_ctrl = wr & (addr == isf_pkg::REG_CTRL);
   assign wr_en = wr & (addr == isf_pkg::REG_ENABLE);
   assign wr_prio = wr & (addr == isf_pkg::REG_PRIORITY);
   assign wr_sw = wr & (addr == isf_pkg::REG_SWFLAG);
   assign wr_ist = wr & (addr == isf_pkg::REG_IRQ_STATUS);
   assign wr_imask = wr & (addr == isf_pkg::REG_IRQ_MASK);

   assign rd_mux = (addr == isf_pkg::REG_CTRL) ? 16'(ctrl_reg) :
      (addr == isf_pkg::REG_ENABLE) ? 16'(enable_reg) :
      (addr == isf_pkg::REG_PRIORITY) ? 16'(prio_reg) :
      (addr == isf_pkg::REG_REQUEST) ? 16'(link.req) :
      (addr == isf_pkg::REG_SWFLAG) ? 16'(link.sw_flags) :
      (addr == isf_pkg::REG_VECTOR) ? 16'({inserv_hi_reg, inserv_lo_reg, vector_id_reg}) :
      (addr == isf_pkg::REG_IRQ_STATUS) ? 16'(irq_status_reg) :
      (addr == isf_pkg::REG_IRQ_MASK) ? 16'(irq_mask_reg) : 16'h0000;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_reg <= isf_pkg::CTRL_RESET;
         enable_reg <= isf_pkg::SRC_RESET;
         prio_reg <= isf_pkg::SRC_RESET;
         irq_mask_reg <= isf_pkg::IRQ_RESET;
      end else begin
         ctrl_reg <= wr_ctrl ? wdata[isf_pkg::CTRL_W-1:0] : ctrl_reg;
         enable_reg <= wr_en ? wdata[isf_pkg::NUM_SRC-1:0] : enable_reg;
         prio_reg <= wr_prio ? wdata[isf_pkg::NUM_SRC-1:0] : prio_reg;
         irq_mask_reg <= wr_imask ? wdata[isf_pkg::IRQ_W-1:0] : irq_mask_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_status_reg <= isf_pkg::IRQ_RESET;
         sw_clear_reg <= isf_pkg::SW_RESET;
         rdata_reg <= 16'h0000;
         irq_reg <= 1'b0;
      end else begin
         irq_status_reg <= irq_set | (irq_status_reg & ~(wr_ist ? wdata[isf_pkg::IRQ_W-1:0] : isf_pkg::IRQ_RESET));
         sw_clear_reg <= wr_sw ? wdata[isf_pkg::NUM_SW-1:0] : isf_pkg::SW_RESET;
         rdata_reg <= rd ? rd_mux : 16'h0000;
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // service level is marked on the same edge as the pulse, so no second take
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         vector_valid_reg <= 1'b0;
         vector_id_reg <= 4'h0;
         inserv_hi_reg <= 1'b0;
         inserv_lo_reg <= 1'b0;
      end else begin
         vector_valid_reg <= take;
         vector_id_reg <= take ? found_id : vector_id_reg;
         inserv_hi_reg <= (inserv_hi_reg & ~ret_hi) | (take & pick_hi);
         inserv_lo_reg <= (inserv_lo_reg & ~ret_lo) | (take & ~pick_hi);
      end
   end

   assign link.ack_valid = vector_valid_reg;
   assign link.ack_id = vector_id_reg;
   assign link.sw_clear = sw_clear_reg;
   assign link.cfg_edge_a = ctrl_reg[isf_pkg::CTRL_EDGE_A];
   assign link.cfg_edge_b = ctrl_reg[isf_pkg::CTRL_EDGE_B];
   assign link.cfg_ext_c_en = ctrl_reg[isf_pkg::CTRL_EXT_C_EN];
   assign link.cfg_adc_sel = ctrl_reg[isf_pkg::CTRL_ADC_SEL];
   assign rdata = rdata_reg;
   assign vector_valid = vector_valid_reg;
   assign vector_id = vector_id_reg;
   assign irq = irq_reg;
endmodule : isf_core_seq
`default_nettype wire

/* hw/isf_flag_dev.sv */
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module isf_flag_dev (
   input wire logic core_clk,
   input wire logic nrst,
   isf_link_if.device link,
   input wire logic ext_request_a_n,
   input wire logic ext_request_b_n,
   input wire logic timer_c_ext_input,
   input wire logic adc_done,
   input wire logic timer_a_ovf,
   input wire logic timer_a_hi_ovf,
   input wire logic timer_a_mode3,
   input wire logic timer_b_ovf,
   input wire logic timer_c_ovf,
   input wire logic twowire_intr,
   input wire logic display_twowire_intr,
   input wire logic ddc1_event,
   input wire logic protocol_switch_event,
   input wire logic [isf_pkg::NUM_USB-1:0] usb_event,
   input wire logic uart_a_irq,
   input wire logic uart_b_irq,
   output logic ext_a_pending_flag,
   output logic ext_b_pending_flag,
   output logic timer_a_overflow_flag,
   output logic timer_b_overflow_flag,
   output logic timer_c_overflow_flag,
   output logic timer_c_ext_flag,
   output logic protocol_switch_flag
);
   logic [isf_pkg::NUM_PIN-1:0] pin_raw;
   logic [isf_pkg::NUM_PIN-1:0] sync1_reg;
   logic [isf_pkg::NUM_PIN-1:0] sync2_reg;
   logic [isf_pkg::NUM_PIN-1:0] prev_reg;
   logic [isf_pkg::NUM_PIN-1:0] pin_fall;
   logic [isf_pkg::NUM_SRC-1:0] ack_hit;
   logic ext_a_reg;
   logic ext_a_next;
   logic ext_b_reg;
   logic ext_b_next;
   logic timer_a_reg;
   logic timer_a_next;
   logic timer_b_reg;
   logic timer_b_next;
   logic timer_b_set;
   logic twowire_reg;
   logic twowire_next;
   logic disp_tw_reg;
   logic disp_tw_next;
   logic uart_a_reg;
   logic uart_b_reg;
   logic timer_c_ext_set;
   logic [isf_pkg::NUM_SW-1:0] sw_set;
   logic [isf_pkg::NUM_SW-1:0] sw_reg;
   logic [isf_pkg::NUM_SW-1:0] sw_next;
   logic [isf_pkg::NUM_SRC-1:0] req_reg;
   logic [isf_pkg::NUM_SRC-1:0] req_next;
   logic usb_any_next;
   logic display_next;
   logic timer_c_next;

   assign pin_raw[isf_pkg::PIN_EXT_A] = ext_request_a_n;
   assign pin_raw[isf_pkg::PIN_EXT_B] = ext_request_b_n;
   assign pin_raw[isf_pkg::PIN_TIMER_C] = timer_c_ext_input;

   // pins are asynchronous: two stages, then edge on the clean copy
   genvar gp;
   generate
      for (gp = 0; gp < isf_pkg::NUM_PIN; gp++) begin : g_pin
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               sync1_reg[gp] <= 1'b1;
               sync2_reg[gp] <= 1'b1;
               prev_reg[gp] <= 1'b1;
            end else begin
               sync1_reg[gp] <= pin_raw[gp];
               sync2_reg[gp] <= sync1_reg[gp];
               prev_reg[gp] <= sync2_reg[gp];
            end
         end
         assign pin_fall[gp] = prev_reg[gp] & ~sync2_reg[gp];
      end
   endgenerate

   genvar ga;
   generate
      for (ga = 0; ga < isf_pkg::NUM_SRC; ga++) begin : g_ack
         assign ack_hit[ga] = link.ack_valid & (link.ack_id == 4'(ga));
      end
   endgenerate

   // in level mode the flag mirrors the pin, so a vector cannot clear it
   assign ext_a_next = link.cfg_edge_a ?
      (pin_fall[isf_pkg::PIN_EXT_A] | (ext_a_reg & ~ack_hit[isf_pkg::SRC_EXT_A])) :
      ~sync2_reg[isf_pkg::PIN_EXT_A];

   // adc completion is a pulse, so it is held like an edge request
   assign ext_b_next = link.cfg_adc_sel ?
      (adc_done | (ext_b_reg & ~ack_hit[isf_pkg::SRC_EXT_B])) :
      link.cfg_edge_b ?
      (pin_fall[isf_pkg::PIN_EXT_B] | (ext_b_reg & ~ack_hit[isf_pkg::SRC_EXT_B])) :
      ~sync2_reg[isf_pkg::PIN_EXT_B];

   // in mode 3 the upper half of timer a owns the timer b flag
   assign timer_b_set = timer_a_mode3 ? timer_a_hi_ovf : timer_b_ovf;
   assign timer_a_next = timer_a_ovf | (timer_a_reg & ~ack_hit[isf_pkg::SRC_TIMER_A]);
   assign timer_b_next = timer_b_set | (timer_b_reg & ~ack_hit[isf_pkg::SRC_TIMER_B]);
   assign twowire_next = twowire_intr | (twowire_reg & ~ack_hit[isf_pkg::SRC_TWOWIRE]);
   assign disp_tw_next = display_twowire_intr | (disp_tw_reg & ~ack_hit[isf_pkg::SRC_DISPLAY]);

   assign timer_c_ext_set = link.cfg_ext_c_en & pin_fall[isf_pkg::PIN_TIMER_C];
   assign sw_set = {usb_event, protocol_switch_event, ddc1_event, timer_c_ext_set, timer_c_ovf};

   // software-cleared flags: a set arriving with the clear still wins
   genvar gs;
   generate
      for (gs = 0; gs < isf_pkg::NUM_SW; gs++) begin : g_sw
         assign sw_next[gs] = sw_set[gs] | (sw_reg[gs] & ~link.sw_clear[gs]);
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               sw_reg[gs] <= 1'b0;
            end else begin
               sw_reg[gs] <= sw_next[gs];
            end
         end
      end
   endgenerate

   assign usb_any_next = |sw_next[isf_pkg::NUM_SW-1:isf_pkg::SW_USB_LO];
   assign display_next = disp_tw_next | sw_next[isf_pkg::SW_DDC1] | sw_next[isf_pkg::SW_SWITCH];
   assign timer_c_next = sw_next[isf_pkg::SW_TIMER_C_OVF] | sw_next[isf_pkg::SW_TIMER_C_EXT];

   // request built from next values so a hardware clear drops it at once
   always_comb begin
      req_next = isf_pkg::SRC_RESET;
      req_next[isf_pkg::SRC_EXT_A] = ext_a_next;
      req_next[isf_pkg::SRC_UART_B] = uart_b_reg;
      req_next[isf_pkg::SRC_TIMER_A] = timer_a_next;
      req_next[isf_pkg::SRC_TWOWIRE] = twowire_next;
      req_next[isf_pkg::SRC_EXT_B] = ext_b_next;
      req_next[isf_pkg::SRC_DISPLAY] = display_next;
      req_next[isf_pkg::SRC_TIMER_B] = timer_b_next;
      req_next[isf_pkg::SRC_USB] = usb_any_next;
      req_next[isf_pkg::SRC_UART_A] = uart_a_reg;
      req_next[isf_pkg::SRC_TIMER_C] = timer_c_next;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ext_a_reg <= 1'b0;
         ext_b_reg <= 1'b0;
         timer_a_reg <= 1'b0;
         timer_b_reg <= 1'b0;
         twowire_reg <= 1'b0;
         disp_tw_reg <= 1'b0;
      end else begin
         ext_a_reg <= ext_a_next;
         ext_b_reg <= ext_b_next;
         timer_a_reg <= timer_a_next;
         timer_b_reg <= timer_b_next;
         twowire_reg <= twowire_next;
         disp_tw_reg <= disp_tw_next;
      end
   end

   // uart flags live in the uarts; only their level is carried here
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         uart_a_reg <= 1'b0;
         uart_b_reg <= 1'b0;
         req_reg <= isf_pkg::SRC_RESET;
      end else begin
         uart_a_reg <= uart_a_irq;
         uart_b_reg <= uart_b_irq;
         req_reg <= req_next;
      end
   end

   assign link.req = req_reg;
   assign link.sw_flags = sw_reg;
   assign ext_a_pending_flag = ext_a_reg;
   assign ext_b_pending_flag = ext_b_reg;
   assign timer_a_overflow_flag = timer_a_reg;
   assign timer_b_overflow_flag = timer_b_reg;
   assign timer_c_overflow_flag = sw_reg[isf_pkg::SW_TIMER_C_OVF];
   assign timer_c_ext_flag = sw_reg[isf_pkg::SW_TIMER_C_EXT];
   assign protocol_switch_flag = sw_reg[isf_pkg::SW_SWITCH];
endmodule : isf_flag_dev
`default_nettype wire

/* hw/isf_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface isf_link_if;
   logic [isf_pkg::NUM_SRC-1:0] req;
   logic [isf_pkg::NUM_SW-1:0] sw_flags;
   logic ack_valid;
   logic [3:0] ack_id;
   logic [isf_pkg::NUM_SW-1:0] sw_clear;
   logic cfg_edge_a;
   logic cfg_edge_b;
   logic cfg_ext_c_en;
   logic cfg_adc_sel;
   modport device (
      output req,
      output sw_flags,
      input ack_valid,
      input ack_id,
      input sw_clear,
      input cfg_edge_a,
      input cfg_edge_b,
      input cfg_ext_c_en,
      input cfg_adc_sel
   );
   modport core (
      input req,
      input sw_flags,
      output ack_valid,
      output ack_id,
      output sw_clear,
      output cfg_edge_a,
      output cfg_edge_b,
      output cfg_ext_c_en,
      output cfg_adc_sel
   );
endinterface : isf_link_if
`default_nettype wire

/* hw/isf_pkg.sv */
// Functional notes
// - ten request sources, each its own line
// - ext a level or falling-edge selectable
// - edge flags cleared on vector, level not
// - level request follows pin; release before return
// - ext b mirrors ext a, own bits
// - adc completion may take ext b path
// - timer a/b flags set by overflow
// - timer a/b flags cleared when serviced
// - timer c overflow cleared by software only
// - timer c ext edge, gated, own flag
// - two-wire flag requests, cleared by hardware
// - display request is or of three flags
// - only display two-wire flag hardware cleared
// - usb endpoint, suspend, resume, eop events request
// - usb flags hold until software clears
// - fixed polling order within each priority level, lowest index wins; the high level goes first
// - per-source enables plus global enable
package isf_pkg;
   localparam int NUM_SRC = 10;
   localparam int NUM_USB = 7;
   localparam int NUM_SW = 11;
   localparam int NUM_PIN = 3;
   localparam logic [3:0] SRC_EXT_A = 4'h0;
   localparam logic [3:0] SRC_UART_B = 4'h1;
   localparam logic [3:0] SRC_TIMER_A = 4'h2;
   localparam logic [3:0] SRC_TWOWIRE = 4'h3;
   localparam logic [3:0] SRC_EXT_B = 4'h4;
   localparam logic [3:0] SRC_DISPLAY = 4'h5;
   localparam logic [3:0] SRC_TIMER_B = 4'h6;
   localparam logic [3:0] SRC_USB = 4'h7;
   localparam logic [3:0] SRC_UART_A = 4'h8;
   localparam logic [3:0] SRC_TIMER_C = 4'h9;
   localparam int SW_TIMER_C_OVF = 0;
   localparam int SW_TIMER_C_EXT = 1;
   localparam int SW_DDC1 = 2;
   localparam int SW_SWITCH = 3;
   localparam int SW_USB_LO = 4;
   localparam int PIN_EXT_A = 0;
   localparam int PIN_EXT_B = 1;
   localparam int PIN_TIMER_C = 2;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ENABLE = 4'h1;
   localparam logic [3:0] REG_PRIORITY = 4'h2;
   localparam logic [3:0] REG_REQUEST = 4'h3;
   localparam logic [3:0] REG_SWFLAG = 4'h4;
   localparam logic [3:0] REG_VECTOR = 4'h5;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
   localparam logic [3:0] REG_IRQ_MASK = 4'h7;
   localparam int CTRL_GLOBAL_EN = 0;
   localparam int CTRL_EDGE_A = 1;
   localparam int CTRL_EDGE_B = 2;
   localparam int CTRL_EXT_C_EN = 3;
   localparam int CTRL_ADC_SEL = 4;
   localparam int CTRL_W = 5;
   localparam int IRQ_VECTOR = 0;
   localparam int IRQ_RETURN = 1;
   localparam int IRQ_W = 2;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [9:0] SRC_RESET = 10'h000;
   localparam logic [10:0] SW_RESET = 11'h000;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage : isf_pkg

/* hw/isf_prio_enc.sv */
`timescale 1ns/1ps
`default_nettype none
module isf_prio_enc (
   input wire logic [isf_pkg::NUM_SRC-1:0] vec,
   output logic found,
   output logic [3:0] id
);
   // scanning downward lets the lowest index overwrite, so it wins
   always_comb begin
      found = 1'b0;
      id = 4'h0;
      for (int i = isf_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (vec[i]) begin
            found = 1'b1;
            id = 4'(i);
         end
      end
   end
endmodule : isf_prio_enc
`default_nettype wire

/* tb/isf_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module isf_link_monitor (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [isf_pkg::NUM_SRC-1:0] req,
   input wire logic [isf_pkg::NUM_SW-1:0] sw_flags,
   input wire logic ack_valid,
   input wire logic [3:0] ack_id,
   input wire logic [isf_pkg::NUM_SW-1:0] sw_clear,
   input wire logic cfg_edge_a,
   input wire logic cfg_edge_b,
   input wire logic cfg_ext_c_en,
   input wire logic cfg_adc_sel
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   a_reset_all_clear: assert property ($rose(nrst) |-> req == '0 && sw_flags == '0)
      else $error("flags not clear after reset");
   a_ack_single_pulse: assert property (ack_valid |=> !ack_valid || ack_id != $past(ack_id))
      else $error("same source acknowledged twice in a row");
   a_ack_was_requested: assert property (ack_valid |-> (($past(req) >> ack_id) & 10'h001) != '0)
      else $error("acknowledge for a source that was not requesting");
   // hardware must never drop a software flag, an acknowledge included
   a_sw_flag_holds: assert property (($past(sw_flags) & ~$past(sw_clear) & ~sw_flags) == '0)
      else $error("software flag dropped without a clear");
   a_timer_c_or: assert property (req[9] == (sw_flags[0] | sw_flags[1]))
      else $error("timer c request not or of its flags");
   a_usb_or: assert property (req[7] == (|sw_flags[10:4]))
      else $error("usb request not or of usb flags");
   a_display_sw_req: assert property ((sw_flags[2] | sw_flags[3]) |-> req[5])
      else $error("display flag set without display request");
   a_ext_a_edge_clear: assert property (ack_valid && ack_id == 4'h0 && cfg_edge_a |=> !req[0])
      else $error("edge request a not cleared by acknowledge");
   a_ext_b_edge_clear: assert property (ack_valid && ack_id == 4'h4 && (cfg_edge_b || cfg_adc_sel) |=> !req[4])
      else $error("edge request b not cleared by acknowledge");
   a_timer_a_clear: assert property (ack_valid && ack_id == 4'h2 |=> !req[2])
      else $error("timer a request not cleared by acknowledge");
   a_ext_c_gated: assert property ($rose(sw_flags[1]) |-> $past(cfg_ext_c_en))
      else $error("timer c external flag set while disabled");
   c_usb_ack: cover property (ack_valid && ack_id == 4'h7);
   c_sw_clear: cover property (sw_clear != '0);
   c_level_ack: cover property (ack_valid && ack_id == 4'h0 && !cfg_edge_a);
endmodule : isf_link_monitor
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk;
   logic nrst;
   logic [isf_pkg::ADDR_W-1:0] addr;
   logic [isf_pkg::DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [isf_pkg::DATA_W-1:0] rdata;
   logic core_ready;
   logic core_return;
   logic vector_valid;
   logic [3:0] vector_id;
   logic irq;
   logic pin_a_n;
   logic pin_b_n;
   logic timer_c_pin;
   logic mode3;
   logic uart_a;
   logic uart_b;
   logic [15:0] ev;
   logic [6:0] fl;
   int n_errors;
   int total_checks;
   int n_vec;
   isf_link_if link_i ();
   isf_flag_dev isf_flag_dev_i (.core_clk(core_clk), .nrst(nrst), .link(link_i.device),
      .ext_request_a_n(pin_a_n), .ext_request_b_n(pin_b_n), .timer_c_ext_input(timer_c_pin), .adc_done(ev[8]),
      .timer_a_ovf(ev[0]), .timer_a_hi_ovf(ev[1]), .timer_a_mode3(mode3), .timer_b_ovf(ev[2]),
      .timer_c_ovf(ev[3]), .twowire_intr(ev[4]), .display_twowire_intr(ev[5]), .ddc1_event(ev[6]),
      .protocol_switch_event(ev[7]), .usb_event(ev[15:9]), .uart_a_irq(uart_a), .uart_b_irq(uart_b),
      .ext_a_pending_flag(fl[0]), .ext_b_pending_flag(fl[1]), .timer_a_overflow_flag(fl[2]),
      .timer_b_overflow_flag(fl[3]), .timer_c_overflow_flag(fl[4]), .timer_c_ext_flag(fl[5]),
      .protocol_switch_flag(fl[6]));
   isf_core_seq isf_core_seq_i (.core_clk(core_clk), .nrst(nrst), .link(link_i.core), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_ready(core_ready), .core_return(core_return),
      .vector_valid(vector_valid), .vector_id(vector_id), .irq(irq));
   isf_link_monitor isf_link_monitor_i (.core_clk(core_clk), .nrst(nrst), .req(link_i.req),
      .sw_flags(link_i.sw_flags), .ack_valid(link_i.ack_valid), .ack_id(link_i.ack_id),
      .sw_clear(link_i.sw_clear), .cfg_edge_a(link_i.cfg_edge_a), .cfg_edge_b(link_i.cfg_edge_b),
      .cfg_ext_c_en(link_i.cfg_ext_c_en), .cfg_adc_sel(link_i.cfg_adc_sel));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      if (vector_valid === 1'b1) n_vec++;
   end
   task automatic end_of_test();
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : check
   task automatic chk_fl(input logic [6:0] exp);
      @(negedge core_clk);
      check("flags", {9'h000, exp}, {9'h000, fl});
   endtask : chk_fl
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   task automatic wr_reg(input logic [isf_pkg::ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [isf_pkg::ADDR_W-1:0] a, input logic [15:0] exp, input string name);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      check(name, exp, rdata);
   endtask : rd_chk
   task automatic pulse(input logic [15:0] m);
      @(posedge core_clk);
      ev <= m;
      @(posedge core_clk);
      ev <= '0;
   endtask : pulse
   // ready drops right after the vector so a level source cannot re-vector here
   task automatic service(input logic [3:0] exp);
      int i;
      @(posedge core_clk);
      core_ready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge core_clk);
         if (vector_valid === 1'b1) break;
      end
      check("vector_id", {12'h000, exp}, {12'h000, vector_id});
      if (i == 40) check("vector_valid", 16'h0001, 16'h0000);
      @(posedge core_clk);
      core_ready <= 1'b0;
      repeat (2) @(posedge core_clk);
      core_return <= 1'b1;
      @(posedge core_clk);
      core_return <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : service
   task automatic no_vec();
      int c;
      c = n_vec;
      @(posedge core_clk);
      core_ready <= 1'b1;
      repeat (10) @(posedge core_clk);
      core_ready <= 1'b0;
      // one more edge so a vector from the last ready edge is counted first
      settle(1);
      check("vector_count", c[15:0], n_vec[15:0]);
   endtask : no_vec
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      int k;
      nrst = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      core_ready = 1'b0;
      core_return = 1'b0;
      pin_a_n = 1'b1;
      pin_b_n = 1'b1;
      timer_c_pin = 1'b1;
      mode3 = 1'b0;
      uart_a = 1'b0;
      uart_b = 1'b0;
      ev = '0;
      n_errors = 0;
      total_checks = 0;
      n_vec = 0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      rd_chk(isf_pkg::REG_CTRL, 16'h0000, "ctrl");
      rd_chk(isf_pkg::REG_SWFLAG, 16'h0000, "swflag");
      rd_chk(4'hf, 16'h0000, "unmapped");
      chk_fl(7'h00);
      wr_reg(isf_pkg::REG_ENABLE, 16'h03ff);
      wr_reg(isf_pkg::REG_IRQ_MASK, 16'h0001);
      wr_reg(isf_pkg::REG_CTRL, 16'h0001);
      pulse(16'h0001);
      settle(1);
      chk_fl(7'h04);
      rd_chk(isf_pkg::REG_REQUEST, 16'h0004, "request");
      service(4'h2);
      chk_fl(7'h00);
      check("irq", 16'h0001, {15'h0000, irq});
      wr_reg(isf_pkg::REG_IRQ_STATUS, 16'h0003);
      settle(2);
      check("irq", 16'h0000, {15'h0000, irq});
      @(posedge core_clk);
      uart_a <= 1'b1;
      uart_b <= 1'b1;
      pulse(16'h0015);
      service(4'h1);
      uart_b <= 1'b0;
      // the uart level passes two registers before the request drops
      settle(2);
      service(4'h2);
      service(4'h3);
      service(4'h6);
      service(4'h8);
      uart_a <= 1'b0;
      wr_reg(isf_pkg::REG_CTRL, 16'h0000);
      pulse(16'h0004);
      no_vec();
      wr_reg(isf_pkg::REG_CTRL, 16'h0001);
      wr_reg(isf_pkg::REG_ENABLE, 16'h03bf);
      no_vec();
      wr_reg(isf_pkg::REG_ENABLE, 16'h03ff);
      service(4'h6);
      mode3 <= 1'b1;
      pulse(16'h0002);
      settle(1);
      chk_fl(7'h08);
      service(4'h6);
      mode3 <= 1'b0;
      wr_reg(isf_pkg::REG_CTRL, 16'h0009);
      pulse(16'h0008);
      timer_c_pin <= 1'b0;
      settle(5);
      chk_fl(7'h30);
      service(4'h9);
      chk_fl(7'h30);
      wr_reg(isf_pkg::REG_SWFLAG, 16'h0003);
      timer_c_pin <= 1'b1;
      settle(2);
      chk_fl(7'h00);
      wr_reg(isf_pkg::REG_CTRL, 16'h0001);
      timer_c_pin <= 1'b0;
      settle(5);
      chk_fl(7'h00);
      @(posedge core_clk) timer_c_pin <= 1'b1;
      pulse(16'h00e0);
      settle(1);
      chk_fl(7'h40);
      service(4'h5);
      rd_chk(isf_pkg::REG_SWFLAG, 16'h000c, "swflag");
      rd_chk(isf_pkg::REG_REQUEST, 16'h0020, "request");
      wr_reg(isf_pkg::REG_SWFLAG, 16'h000c);
      rd_chk(isf_pkg::REG_REQUEST, 16'h0000, "request");
      for (k = 0; k < 7; k++) begin
         pulse(16'h0200 << k);
         service(4'h7);
         rd_chk(isf_pkg::REG_SWFLAG, 16'h0010 << k, "swflag");
         wr_reg(isf_pkg::REG_SWFLAG, 16'h0010 << k);
      end
      rd_chk(isf_pkg::REG_REQUEST, 16'h0000, "request");
      wr_reg(isf_pkg::REG_CTRL, 16'h0003);
      pin_a_n <= 1'b0;
      settle(5);
      chk_fl(7'h01);
      service(4'h0);
      chk_fl(7'h00);
      @(posedge core_clk) pin_a_n <= 1'b1;
      wr_reg(isf_pkg::REG_CTRL, 16'h0001);
      pin_a_n <= 1'b0;
      settle(5);
      service(4'h0);
      chk_fl(7'h01);
      @(posedge core_clk) pin_a_n <= 1'b1;
      settle(5);
      chk_fl(7'h00);
      wr_reg(isf_pkg::REG_CTRL, 16'h0005);
      pin_b_n <= 1'b0;
      settle(5);
      chk_fl(7'h02);
      service(4'h4);
      chk_fl(7'h00);
      wr_reg(isf_pkg::REG_CTRL, 16'h0011);
      pulse(16'h0100);
      settle(1);
      chk_fl(7'h02);
      service(4'h4);
      chk_fl(7'h00);
      // a high-level source beats a lower index of the low level
      wr_reg(isf_pkg::REG_PRIORITY, 16'h0040);
      rd_chk(isf_pkg::REG_PRIORITY, 16'h0040, "priority");
      pulse(16'h0005);
      service(4'h6);
      service(4'h2);
      rd_chk(isf_pkg::REG_VECTOR, 16'h0002, "vector");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
